// File: hw/rfc_pkg.sv
// Purpose: constants and types for the resistance to frequency converter channel
// Assumes: one channel per instance, 20 MHz operating clock
// Notes: control bits travel as packed structs
package rfc_pkg;
  localparam int CNT_W = 24;
  localparam logic [23:0] CNT_RESET = 24'h00_0000;
  localparam logic [23:0] CNT_ALL_ONES = 24'hff_ffff;
  localparam logic [1:0] MODE_DC = 2'h0;
  localparam logic [1:0] MODE_AC = 2'h1;
  localparam int FLAG_REF_DONE = 0;
  localparam int FLAG_TB_OVF = 1;
  localparam int FLAG_SEN_A_DONE = 2;
  localparam int FLAG_SEN_B_DONE = 3;
  localparam int FLAG_MEAS_OVF = 4;
  localparam logic [4:0] FLAGS_RESET = 5'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REF = 2'b01,
    ST_SEN_A = 2'b10,
    ST_SEN_B = 2'b11
  } phase_e;

  // software control bits and strobes
  typedef struct packed {
    logic channel_enable;
    logic [1:0] oscillation_mode_select;
    logic external_clock_mode_enable;
    logic trig_write;
    logic reference_start;
    logic sensor_a_start;
    logic sensor_b_start;
  } ctrl_s;

  // counter preset strobes and values
  typedef struct packed {
    logic meas_load;
    logic [23:0] meas_value;
    logic tb_load;
    logic [23:0] tb_value;
  } preset_s;
endpackage

// File: hw/resistance_frequency_converter.sv
// Purpose: one channel sequencer of the resistance to frequency converter
// Assumes: oscillation and external clocks arrive synchronous to I_SYS_CLK
// Notes: flags clear by write-one; a set in the same cycle wins over the clear
`timescale 1ns/1ps
`default_nettype none
module resistance_frequency_converter (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire rfc_pkg::ctrl_s I_CTRL,
  input wire rfc_pkg::preset_s I_PRESET,
  input wire logic [4:0] I_FLAG_CLEAR,
  input wire logic [4:0] I_IRQ_ENABLE,
  input wire logic I_OSC_CLK,
  input wire logic I_EXT_CLK,
  output logic O_REF_DRIVE,
  output logic O_SEN_A_DRIVE,
  output logic O_SEN_B_DRIVE,
  output logic [2:0] O_START_STATUS,
  output logic [23:0] O_MEAS_COUNT,
  output logic [23:0] O_TB_COUNT,
  output logic [4:0] O_FLAGS,
  output logic [4:0] O_IRQ
);
  import rfc_pkg::*;

  phase_e phase_r, phase_nxt;
  logic [23:0] meas_r, meas_nxt;
  logic [23:0] tb_r, tb_nxt;
  logic [4:0] flags_r, flags_nxt;
  logic [4:0] irq_r, irq_nxt;
  logic [2:0] drive_r, drive_nxt;
  logic cnt_clk_d_r, cnt_clk_d_nxt;
  logic cnt_clk, cnt_edge;
  logic meas_wrap, tb_wrap, tb_zero;
  logic ac_mode;

  // counter increment with wrap detection
  function automatic logic [24:0] inc24(input logic [23:0] v);
    inc24 = {1'b0, v} + 25'd1;
  endfunction

  // source select and rising edge detect of the counting clock
  always_comb begin
    cnt_clk = I_CTRL.external_clock_mode_enable ? I_EXT_CLK : I_OSC_CLK;
    cnt_edge = cnt_clk & ~cnt_clk_d_r;
    cnt_clk_d_nxt = cnt_clk;
    ac_mode = (I_CTRL.oscillation_mode_select == MODE_AC);
    meas_wrap = cnt_edge && (meas_r == CNT_ALL_ONES);
    tb_wrap = (tb_r == CNT_ALL_ONES);
    tb_zero = (tb_r == 24'h00_0001);
  end

  // phase sequencing, counters and flags
  always_comb begin
    logic [24:0] m_inc;
    logic [24:0] t_inc;
    m_inc = inc24(meas_r);
    t_inc = inc24(tb_r);
    phase_nxt = phase_r;
    meas_nxt = meas_r;
    tb_nxt = tb_r;
    flags_nxt = flags_r & ~I_FLAG_CLEAR;
    case (phase_r)
      ST_IDLE: begin
        // counters hold until written or restarted
        if (I_CTRL.trig_write && I_CTRL.channel_enable) begin
          if (I_CTRL.reference_start) begin
            phase_nxt = ST_REF;
          end else if (I_CTRL.sensor_a_start) begin
            phase_nxt = ST_SEN_A;
            meas_nxt = CNT_RESET;
          end else if (I_CTRL.sensor_b_start && !ac_mode) begin
            phase_nxt = ST_SEN_B;
            meas_nxt = CNT_RESET;
          end
        end
      end
      ST_REF: begin
        if (I_CTRL.trig_write && I_CTRL.channel_enable && !I_CTRL.reference_start) begin
          phase_nxt = ST_IDLE;
        end else begin
          if (cnt_edge) begin
            meas_nxt = m_inc[23:0];
          end
          tb_nxt = t_inc[23:0];
          if (meas_wrap || tb_wrap) begin
            phase_nxt = ST_IDLE;
          end
          if (meas_wrap) begin
            flags_nxt[FLAG_REF_DONE] = 1'b1;
          end
          if (tb_wrap) begin
            flags_nxt[FLAG_TB_OVF] = 1'b1;
          end
        end
      end
      ST_SEN_A, ST_SEN_B: begin
        if (I_CTRL.trig_write && I_CTRL.channel_enable &&
            !(phase_r == ST_SEN_A ? I_CTRL.sensor_a_start : I_CTRL.sensor_b_start)) begin
          phase_nxt = ST_IDLE;
        end else if (tb_r == CNT_RESET) begin
          phase_nxt = ST_IDLE;
          flags_nxt[phase_r == ST_SEN_A ? FLAG_SEN_A_DONE : FLAG_SEN_B_DONE] = 1'b1;
        end else begin
          if (cnt_edge) begin
            meas_nxt = m_inc[23:0];
          end
          tb_nxt = tb_r - 24'h00_0001;
          if (tb_zero) begin
            phase_nxt = ST_IDLE;
            flags_nxt[phase_r == ST_SEN_A ? FLAG_SEN_A_DONE : FLAG_SEN_B_DONE] = 1'b1;
          end else if (meas_wrap) begin
            phase_nxt = ST_IDLE;
            flags_nxt[FLAG_MEAS_OVF] = 1'b1;
          end
        end
      end
      default: begin
        phase_nxt = ST_IDLE;
      end
    endcase
    // a software preset wins over counting in the same cycle
    if (I_PRESET.meas_load) begin
      meas_nxt = I_PRESET.meas_value;
    end
    if (I_PRESET.tb_load) begin
      tb_nxt = I_PRESET.tb_value;
    end
    irq_nxt = flags_nxt & I_IRQ_ENABLE;
  end

  // drive and start status bits follow the next phase
  always_comb begin
    drive_nxt[0] = (phase_nxt == ST_REF);
    drive_nxt[1] = (phase_nxt == ST_SEN_A);
    drive_nxt[2] = (phase_nxt == ST_SEN_B);
  end

  // state registers
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      phase_r <= ST_IDLE;
      meas_r <= CNT_RESET;
      tb_r <= CNT_RESET;
      flags_r <= FLAGS_RESET;
      irq_r <= FLAGS_RESET;
      cnt_clk_d_r <= 1'b0;
      drive_r <= 3'b000;
    end else begin
      phase_r <= phase_nxt;
      meas_r <= meas_nxt;
      tb_r <= tb_nxt;
      flags_r <= flags_nxt;
      irq_r <= irq_nxt;
      cnt_clk_d_r <= cnt_clk_d_nxt;
      drive_r <= drive_nxt;
    end
  end

  // outputs straight from flip-flops
  always_comb begin
    O_REF_DRIVE = drive_r[0];
    O_SEN_A_DRIVE = drive_r[1];
    O_SEN_B_DRIVE = drive_r[2];
    O_START_STATUS = drive_r;
    O_MEAS_COUNT = meas_r;
    O_TB_COUNT = tb_r;
    O_FLAGS = flags_r;
    O_IRQ = irq_r;
  end

  // measurement wrap ends the reference phase normally
  a_ref_done_flag: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (phase_r == ST_REF && meas_wrap && !I_CTRL.trig_write) |=> (flags_r[FLAG_REF_DONE] && phase_r == ST_IDLE))
    else $error("reference done not raised on wrap");

  // time base wrap ends the reference phase with an error
  a_tb_ovf_flag: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (phase_r == ST_REF && tb_wrap && !I_CTRL.trig_write) |=> (flags_r[FLAG_TB_OVF] && phase_r == ST_IDLE))
    else $error("time base overflow not flagged");

  // time base climbs by one per cycle in the reference phase
  a_ref_tb_counts: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (phase_r == ST_REF && phase_nxt == ST_REF && !I_PRESET.tb_load) |=> (tb_r == $past(tb_r) + 24'h00_0001))
    else $error("time base not counting up");

  // sensor a finishes when the time base reaches zero
  a_sen_done_flag: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (phase_r == ST_SEN_A && tb_zero && !I_CTRL.trig_write) |=> (flags_r[FLAG_SEN_A_DONE] && tb_r == CNT_RESET))
    else $error("sensor a done not raised at zero");

  // measurement wrap in a sensor phase is an error
  a_meas_ovf_flag: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ((phase_r == ST_SEN_A || phase_r == ST_SEN_B) && meas_wrap && !tb_zero && tb_r != CNT_RESET
     && !I_CTRL.trig_write) |=> flags_r[FLAG_MEAS_OVF])
    else $error("measurement overflow not flagged");

  // irq lines are the flags masked by last cycle's enables
  a_irq_gate: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ##1 (O_IRQ == (O_FLAGS & $past(I_IRQ_ENABLE))))
    else $error("irq not gated by enable");

  // a zero to the active start bit stops and freezes both counters
  a_abort_holds: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (phase_r != ST_IDLE && I_CTRL.trig_write && I_CTRL.channel_enable && !I_CTRL.reference_start
     && !I_CTRL.sensor_a_start && !I_CTRL.sensor_b_start && !I_PRESET.meas_load && !I_PRESET.tb_load)
    |=> (phase_r == ST_IDLE && tb_r == $past(tb_r) && meas_r == $past(meas_r)))
    else $error("abort did not hold counters");

  // a disabled channel never leaves idle
  a_disabled_ignore: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (phase_r == ST_IDLE && !I_CTRL.channel_enable) |=> (phase_r == ST_IDLE))
    else $error("start accepted while disabled");

  // ac mode has no sensor b path
  a_ac_no_b: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (phase_r == ST_IDLE && ac_mode) |=> (phase_r != ST_SEN_B))
    else $error("sensor b started in ac mode");

  // stopped counters keep their values
  a_idle_hold: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (phase_r == ST_IDLE && phase_nxt == ST_IDLE && !I_PRESET.meas_load && !I_PRESET.tb_load)
    |=> (meas_r == $past(meas_r) && tb_r == $past(tb_r)))
    else $error("counters moved while stopped");

  // measurement advances by one on a counting edge
  a_ref_meas_count: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (phase_r == ST_REF && phase_nxt == ST_REF && cnt_edge && !I_PRESET.meas_load)
    |=> (meas_r == $past(meas_r) + 24'h00_0001))
    else $error("measurement not counting on edge");

  // measurement stands still between counting edges
  a_meas_no_edge: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (phase_r == ST_REF && !cnt_edge && !I_PRESET.meas_load) |=> (meas_r == $past(meas_r)))
    else $error("measurement moved without edge");

  // time base counts down by one in a sensor phase
  a_sen_tb_down: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ((phase_r == ST_SEN_A || phase_r == ST_SEN_B) && phase_nxt == phase_r && !I_PRESET.tb_load)
    |=> (tb_r == $past(tb_r) - 24'h00_0001))
    else $error("time base not counting down");

  // a sensor start clears the measurement counter
  a_sen_meas_clear: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (phase_r == ST_IDLE && (phase_nxt == ST_SEN_A || phase_nxt == ST_SEN_B) && !I_PRESET.meas_load)
    |=> (meas_r == CNT_RESET))
    else $error("measurement not cleared at sensor start");

  // reference start raises the drive and its status bit
  a_ref_start: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (phase_r == ST_IDLE && I_CTRL.trig_write && I_CTRL.channel_enable && I_CTRL.reference_start)
    |=> (O_REF_DRIVE && O_START_STATUS == 3'b001))
    else $error("reference start not taken");

  // sensor a start raises its drive
  a_sen_a_start: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (phase_r == ST_IDLE && I_CTRL.trig_write && I_CTRL.channel_enable && !I_CTRL.reference_start
     && I_CTRL.sensor_a_start) |=> O_SEN_A_DRIVE)
    else $error("sensor a start not taken");

  // registered status tracks the running phase
  a_status_phase: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    O_START_STATUS == {phase_r == ST_SEN_B, phase_r == ST_SEN_A, phase_r == ST_REF})
    else $error("start status does not match phase");

  // at most one network is driven at a time
  a_drive_onehot: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    $onehot0({O_SEN_B_DRIVE, O_SEN_A_DRIVE, O_REF_DRIVE}))
    else $error("more than one network driven");

  // sensor b finishes when the time base reaches zero
  a_sen_b_done: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (phase_r == ST_SEN_B && tb_zero && !I_CTRL.trig_write) |=> (flags_r[FLAG_SEN_B_DONE] && phase_r == ST_IDLE))
    else $error("sensor b done not raised at zero");

  // time base wrap leaves zero and stops the drive
  a_ref_tb_wrap: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (phase_r == ST_REF && tb_wrap && !I_CTRL.trig_write && !I_PRESET.tb_load)
    |=> (tb_r == CNT_RESET && !O_REF_DRIVE))
    else $error("reference not stopped on time base wrap");

  // measurement wrap in a sensor phase stops at zero
  a_sen_meas_wrap: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ((phase_r == ST_SEN_A || phase_r == ST_SEN_B) && meas_wrap && !tb_zero && tb_r != CNT_RESET
     && !I_CTRL.trig_write && !I_PRESET.meas_load) |=> (meas_r == CNT_RESET && phase_r == ST_IDLE))
    else $error("sensor not stopped on measurement wrap");

  // external pulses count in place of the oscillator
  a_ext_count: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (phase_r == ST_REF && phase_nxt == ST_REF && I_CTRL.external_clock_mode_enable && I_EXT_CLK
     && !cnt_clk_d_r && !I_PRESET.meas_load) |=> (meas_r == $past(meas_r) + 24'h00_0001))
    else $error("external pulse not counted");

  // main scenarios
  c_ref_done: cover property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    phase_r == ST_REF ##1 flags_r[FLAG_REF_DONE]);
  c_sen_a_done: cover property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    phase_r == ST_SEN_A ##1 flags_r[FLAG_SEN_A_DONE]);
  c_sen_b_ovf: cover property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    phase_r == ST_SEN_B ##1 flags_r[FLAG_MEAS_OVF]);
  c_abort: cover property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    phase_r == ST_REF ##1 (phase_r == ST_IDLE && !flags_r[FLAG_REF_DONE] && !flags_r[FLAG_TB_OVF]));
  c_tb_ovf: cover property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    phase_r == ST_REF ##1 flags_r[FLAG_TB_OVF]);
endmodule
`default_nettype wire

// File: bench/osc_model.sv
// Purpose: oscillator model for the reference and sensor networks
// Assumes: it oscillates only while one of the drive lines is high
// Notes: half period is given in operating clock cycles
`timescale 1ns/1ps
`default_nettype none
module osc_model (
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic [3:0] i_half,
  output logic o_osc
);
  logic [3:0] cnt;
  initial begin
    cnt = 4'h0;
    o_osc = 1'b0;
  end
  // the network stands still at low while no drive is applied
  always @(posedge i_clk) begin
    if (!i_run) begin
      cnt <= 4'h0;
      o_osc <= 1'b0;
    end else if (cnt + 4'h1 >= i_half) begin
      cnt <= 4'h0;
      o_osc <= ~o_osc;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: bench/resistance_frequency_converter_tb_top.sv
// Purpose: self-checking bench for one converter channel
// Assumes: oscillator model on the far side, bench acts as software
// Notes: sensor runs are table rows, the rest are hand tests
`timescale 1ns/1ps
`default_nettype none
module resistance_frequency_converter_tb_top;
  import rfc_pkg::*;
  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] start;
    logic [23:0] tb;
    logic [4:0] flags;
  } row_s;
  logic clk, rst_n, osc, ext, ext_on, ref_d, sa_d, sb_d;
  ctrl_s ctrl;
  preset_s pre;
  logic [4:0] fclr, irq_en, flags, irq;
  logic [3:0] half;
  logic [2:0] stat;
  logic [23:0] mc, tc, hold_tc, hold_mc;
  int errors, checked;
  int cycles = 0;
  // mode, start bits, time base preset, expected flags; ac rows start sensor a or b, the b start is refused
  row_s rows [6] = '{'{2'h0, 3'h2, 24'h00_0003, 5'h04}, '{2'h0, 3'h4, 24'h00_0004, 5'h08},
    '{2'h1, 3'h2, 24'h00_0002, 5'h04}, '{2'h1, 3'h4, 24'h00_0002, 5'h00},
    '{2'h2, 3'h4, 24'h00_0001, 5'h08}, '{2'h0, 3'h2, 24'h00_0000, 5'h04}};
  resistance_frequency_converter u_dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_CTRL(ctrl), .I_PRESET(pre),
    .I_FLAG_CLEAR(fclr), .I_IRQ_ENABLE(irq_en), .I_OSC_CLK(osc), .I_EXT_CLK(ext), .O_REF_DRIVE(ref_d),
    .O_SEN_A_DRIVE(sa_d), .O_SEN_B_DRIVE(sb_d), .O_START_STATUS(stat), .O_MEAS_COUNT(mc),
    .O_TB_COUNT(tc), .O_FLAGS(flags), .O_IRQ(irq));
  osc_model u_osc (.i_clk(clk), .i_run(ref_d | sa_d | sb_d), .i_half(half), .o_osc(osc));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic trig(input logic [2:0] s);
    ctrl.trig_write = 1'b1;
    {ctrl.sensor_b_start, ctrl.sensor_a_start, ctrl.reference_start} = s;
    tick(1);
    ctrl.trig_write = 1'b0;
  endtask
  // clear all flags and preset both counters in one cycle
  task automatic setup(input logic [23:0] m, input logic [23:0] t);
    fclr = 5'h1f;
    pre = '{1'b1, m, 1'b1, t};
    tick(1);
    fclr = 5'h00;
    pre.meas_load = 1'b0;
    pre.tb_load = 1'b0;
  endtask
  task automatic wait_idle(input int n);
    int k;
    k = 0;
    tick(1);
    while (stat !== 3'h0 && k < n) begin
      tick(1);
      k++;
    end
    tick(1);
  endtask
  task automatic print_verdict();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // external pulses and the hang limit
  always @(posedge clk) begin
    if (ext_on) ext <= ~ext;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    ctrl = '0; pre = '0; fclr = 5'h00; irq_en = 5'h1f; half = 4'h2;
    ext = 1'b0; ext_on = 1'b0; rst_n = 1'b0; errors = 0; checked = 0;
    ctrl.channel_enable = 1'b1;
    tick(2);
    check({8'h00, flags, irq, stat, ref_d, sa_d, sb_d}, 24'h00_0000);
    check(mc | tc, 24'h00_0000);
    rst_n = 1'b1;
    tick(1);
    foreach (rows[i]) begin
      ctrl.oscillation_mode_select = rows[i].mode;
      setup(24'h00_0000, rows[i].tb);
      trig(rows[i].start);
      wait_idle(40);
      check({19'h0_0000, flags}, {19'h0_0000, rows[i].flags});
      check({19'h0_0000, irq}, {19'h0_0000, rows[i].flags});
      check(tc, rows[i].flags == 5'h00 ? rows[i].tb : 24'h00_0000);
    end
    // reference run with interrupts masked, then sensor from the kept count
    ctrl.oscillation_mode_select = MODE_DC;
    irq_en = 5'h00;
    setup(24'hff_fffc, 24'h00_0000);
    trig(3'h1);
    tick(1);
    check({21'h00_0000, stat}, 24'h00_0001);
    wait_idle(100);
    check({14'h0000, flags, irq}, {14'h0000, 5'h01, 5'h00});
    check(mc, 24'h00_0000);
    hold_tc = tc;
    tick(3);
    check(tc, hold_tc);
    fclr = 5'h1f;
    trig(3'h2);
    fclr = 5'h00;
    wait_idle(200);
    check({16'h0000, tc[23:16], flags}, {16'h0000, 8'h00, 5'h04});
    // time base wraps first in reference
    half = 4'h8;
    setup(24'h00_0000, 24'hff_fff8);
    trig(3'h1);
    wait_idle(40);
    check({19'h0_0000, flags}, 24'h00_0002);
    // measurement wraps during sensor run
    half = 4'h2;
    setup(24'h00_0000, 24'h00_0100);
    trig(3'h2);
    pre.meas_load = 1'b1;
    pre.meas_value = 24'hff_fffe;
    tick(1);
    pre.meas_load = 1'b0;
    wait_idle(60);
    check({19'h0_0000, flags}, 24'h00_0010);
    // abort in mid-run, counters must hold
    setup(24'h00_0000, 24'h00_0100);
    trig(3'h2);
    tick(4);
    trig(3'h0);
    tick(2);
    hold_tc = tc;
    hold_mc = mc;
    tick(4);
    check({16'h0000, flags, stat}, 24'h00_0000);
    check(tc ^ hold_tc | mc ^ hold_mc, 24'h00_0000);
    // start writes refused while disabled
    ctrl.channel_enable = 1'b0;
    trig(3'h1);
    tick(2);
    check({21'h00_0000, stat}, 24'h00_0000);
    ctrl.channel_enable = 1'b1;
    // external pulses replace the slow oscillator
    ctrl.external_clock_mode_enable = 1'b1;
    half = 4'hf;
    setup(24'hff_fffd, 24'h00_0000);
    ext_on = 1'b1;
    trig(3'h1);
    wait_idle(30);
    check({19'h0_0000, flags}, 24'h00_0001);
    ext_on = 1'b0;
    print_verdict();
  end
endmodule
`default_nettype wire
